// file: core/sample_monitor_defines.vh
// register offsets, field positions, reset values and timing counts of the sample monitor
// included by the sample monitor design files; definitions only
`ifndef SAMPLE_MONITOR_DEFINES_VH
`define SAMPLE_MONITOR_DEFINES_VH

// register byte offsets on the wishbone slave
`define ADR_VOLT_PEAK 8'h00
`define ADR_CUR_PEAK 8'h04
`define ADR_DC_PERIOD 8'h08
`define ADR_CONTROL 8'h0c
`define ADR_MAX_DELTA 8'h10
`define ADR_COMMON_MODE 8'h14
`define ADR_STATUS 8'h18
`define ADR_COMP_VALUE 8'h1c

// reset values
`define RST_VOLT_PEAK 15'h7fff
`define RST_CUR_PEAK 15'h7fff
`define RST_DC_PERIOD 6'h05
`define RST_MAX_DELTA 16'h0000
`define RST_COMMON_MODE 16'h0000

// limits
`define DC_PERIOD_MAX 6'h32
`define CROSS_MARGIN 17'h001f6
`define WATCHDOG_LIMIT 8'h8e
`define EXCEED_RUN 2'h3

// control register fields
`define CTL_VOLT_DC 0
`define CTL_CUR1_DC 1
`define CTL_CUR2_DC 2
`define CTL_SPIKE_EN 3
`define CTL_LEVEL_MODE 4

// status register fields
`define ST_VOLT_PEAK 0
`define ST_CUR1_PEAK 1
`define ST_CUR2_PEAK 2
`define ST_WD_LSB 8

// divider
`define DIV_STEPS 6'h20

`endif

// file: core/comp_divider.v
// serial restoring divider for the common-mode compensation value
// assumes start is a one-cycle pulse and divisor is nonzero when used
`timescale 1ns/1ps
`include "sample_monitor_defines.vh"

module comp_divider (
	// clock and reset
	input wire ref_clk,
	input wire rst,
	// request
	input wire start,
	input wire [31:0] dividend,
	input wire [17:0] divisor,
	// answer
	output reg busy,
	output reg done,
	output reg [31:0] quotient
);

	reg [5:0] stepCount;
	reg [18:0] remainder;
	wire [19:0] shifted;
	wire [19:0] trial;

	assign shifted = {remainder, quotient[31]};
	assign trial = shifted - {2'b00, divisor};

	always @(posedge ref_clk) begin
		if (rst) begin
			busy <= 1'b0;
			done <= 1'b0;
			quotient <= 32'h00000000;
			remainder <= 19'h00000;
			stepCount <= 6'h00;
		end else if (start && !busy) begin
			busy <= 1'b1;
			done <= 1'b0;
			quotient <= dividend;
			remainder <= 19'h00000;
			stepCount <= `DIV_STEPS;
		end else if (busy) begin
			if (!trial[19]) begin
				remainder <= trial[18:0];
				quotient <= {quotient[30:0], 1'b1};
			end else begin
				remainder <= shifted[18:0];
				quotient <= {quotient[30:0], 1'b0};
			end
			stepCount <= stepCount - 6'h01;
			if (stepCount == 6'h01) begin
				busy <= 1'b0;
				done <= 1'b1;
			end
		end else begin
			done <= 1'b0;
		end
	end

endmodule // comp_divider

// file: core/metering_sample_monitor.v
// sample-level monitor: overpeak flags, spike filter, zero crossing, watchdog,
// dc-removal offset gating and common-mode compensation of active energies
// assumes samples and energy results come from logic on ref_clk with one-cycle strobes
//
// Functional notes
// - voltage flag after three samples above threshold
// - voltage threshold 15 bits, resets to 0x7fff
// - each current channel flagged after three exceedances
// - current threshold 15 bits, resets to 0x7fff
// - dc period 6 bits, max 0x32, reset 5
// - per-path dc enable; disabled path uses zero
// - crossing: sign change after two opposite samples
// - crossing valid only with 502-step margins
// - filter off passes voltage samples unchanged
// - large step replaced by linear extrapolation
// - watchdog counts samples, cleared by valid crossing
// - watchdog at 142 counts as a dc period, clears
// - zero common-mode parameter disables compensation
// - compensation is rms squared over four times parameter
// - block energies use same block's compensation
// - period energies use previous block's compensation
// - level energy, mode 0, uses previous compensation
// - reactive uncorrected; apparent from corrected active
`timescale 1ns/1ps
`include "sample_monitor_defines.vh"

module metering_sample_monitor (
	// clock and reset
	input wire ref_clk,
	input wire rst,
	// wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// sample stream
	input wire sampleStrobe,
	input wire [15:0] voltSample,
	input wire [15:0] curSample1,
	input wire [15:0] curSample2,
	// offsets from the dc-removal arithmetic
	input wire [15:0] voltOffsetIn,
	input wire [15:0] curOffset1In,
	input wire [15:0] curOffset2In,
	// energy results from the accumulator
	input wire [15:0] voltageRmsResult,
	input wire blockDone,
	input wire [31:0] firstBlockActiveEnergyIn,
	input wire [31:0] secondBlockActiveEnergyIn,
	input wire [31:0] blockReactiveEnergyIn,
	input wire periodDone,
	input wire [31:0] firstPeriodActiveEnergyIn,
	input wire [31:0] secondPeriodActiveEnergyIn,
	input wire levelUpdate,
	input wire [31:0] levelActiveEnergyIn,
	// sample results
	output reg [15:0] filteredVoltSample,
	output reg filteredStrobe,
	output reg voltageOverpeakFlag,
	output reg firstChannelOvercurrentFlag,
	output reg secondChannelOvercurrentFlag,
	output reg crossingPulse,
	output reg dcRemovalStep,
	output reg [15:0] voltOffset,
	output reg [15:0] curOffset1,
	output reg [15:0] curOffset2,
	// corrected energies
	output reg blockValid,
	output reg [31:0] firstBlockActiveEnergy,
	output reg [31:0] secondBlockActiveEnergy,
	output reg [31:0] blockReactiveEnergy,
	output reg [63:0] blockApparentSquare,
	output reg periodValid,
	output reg [31:0] firstPeriodActiveEnergy,
	output reg [31:0] secondPeriodActiveEnergy,
	output reg levelValid,
	output reg [31:0] levelActiveEnergy
);

	// magnitude of a signed 16-bit word, 17 bits so -32768 stays exact
	function [16:0] magnitude;
		input [15:0] value;
		begin
			if (value[15])
				magnitude = 17'h00000 - {value[15], value};
			else
				magnitude = {1'b0, value};
		end
	endfunction

	// byte-lane merge for register writes
	function [31:0] laneMerge;
		input [31:0] old;
		input [31:0] data;
		input [3:0] sel;
		integer i;
		begin
			laneMerge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (sel[i])
					laneMerge[i*8 +: 8] = data[i*8 +: 8];
			end
		end
	endfunction

	// registers
	reg [14:0] voltagePeakThreshold;
	reg [14:0] currentPeakThreshold;
	reg [5:0] dcRemovalPeriodCount;
	reg [4:0] control;
	reg [15:0] maxSampleDelta;
	reg [15:0] commonModeParameter;
	reg [31:0] commonModeCompensationValue;
	reg [31:0] prevCompensation;
	reg [7:0] watchdogCount;

	wire wbRequest;
	wire [31:0] mergedData;
	reg [31:0] readData;
	reg [31:0] writeOld;
	wire [5:0] periodWrite;

	assign wbRequest = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign mergedData = laneMerge(writeOld, wb_dat_i, wb_sel_i);
	assign periodWrite = (mergedData[5:0] > `DC_PERIOD_MAX) ? `DC_PERIOD_MAX : mergedData[5:0];

	always @* begin
		readData = 32'h00000000;
		case (wb_adr_i)
			`ADR_VOLT_PEAK: readData = {17'h00000, voltagePeakThreshold};
			`ADR_CUR_PEAK: readData = {17'h00000, currentPeakThreshold};
			`ADR_DC_PERIOD: readData = {26'h0000000, dcRemovalPeriodCount};
			`ADR_CONTROL: readData = {27'h0000000, control};
			`ADR_MAX_DELTA: readData = {16'h0000, maxSampleDelta};
			`ADR_COMMON_MODE: readData = {16'h0000, commonModeParameter};
			`ADR_STATUS: readData = {16'h0000, watchdogCount, 5'h00, secondChannelOvercurrentFlag,
				firstChannelOvercurrentFlag, voltageOverpeakFlag};
			`ADR_COMP_VALUE: readData = commonModeCompensationValue;
			default: readData = 32'h00000000;
		endcase
		writeOld = readData;
	end

	always @(posedge ref_clk) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			voltagePeakThreshold <= `RST_VOLT_PEAK;
			currentPeakThreshold <= `RST_CUR_PEAK;
			dcRemovalPeriodCount <= `RST_DC_PERIOD;
			control <= 5'h00;
			maxSampleDelta <= `RST_MAX_DELTA;
			commonModeParameter <= `RST_COMMON_MODE;
		end else begin
			wb_ack_o <= wbRequest;
			wb_dat_o <= (wbRequest && !wb_we_i) ? readData : 32'h00000000;
			if (wbRequest && wb_we_i) begin
				case (wb_adr_i)
					`ADR_VOLT_PEAK: voltagePeakThreshold <= mergedData[14:0];
					`ADR_CUR_PEAK: currentPeakThreshold <= mergedData[14:0];
					`ADR_DC_PERIOD: dcRemovalPeriodCount <= periodWrite;
					`ADR_CONTROL: control <= mergedData[4:0];
					`ADR_MAX_DELTA: maxSampleDelta <= mergedData[15:0];
					`ADR_COMMON_MODE: commonModeParameter <= mergedData[15:0];
					default: control <= control;
				endcase
			end
		end
	end

	// spike filter on the voltage path
	reg [15:0] voltHist1;
	reg [15:0] voltHist2;
	wire [16:0] stepDiff;
	wire [16:0] stepSize;
	wire [17:0] extrapolated;
	reg [15:0] next_voltFiltered;

	assign stepDiff = {voltSample[15], voltSample} - {voltHist1[15], voltHist1};
	assign stepSize = stepDiff[16] ? (17'h00000 - stepDiff) : stepDiff;
	assign extrapolated = {voltHist1[15], voltHist1, 1'b0} - {{2{voltHist2[15]}}, voltHist2};

	always @* begin
		next_voltFiltered = voltSample;
		if (control[`CTL_SPIKE_EN] && (stepSize >= {1'b0, maxSampleDelta})) begin
			if (extrapolated[17] && !(&extrapolated[16:15]))
				next_voltFiltered = 16'h8000;
			else if (!extrapolated[17] && (|extrapolated[16:15]))
				next_voltFiltered = 16'h7fff;
			else
				next_voltFiltered = extrapolated[15:0];
		end
	end

	// zero crossing detection with noise margins
	wire newPositive;
	wire newNegative;
	wire histPositive;
	wire histNegative;
	wire marginsOk;
	wire validCrossing;

	assign newPositive = !next_voltFiltered[15] && (next_voltFiltered != 16'h0000);
	assign newNegative = next_voltFiltered[15];
	assign histPositive = !voltHist1[15] && (voltHist1 != 16'h0000) && !voltHist2[15] && (voltHist2 != 16'h0000);
	assign histNegative = voltHist1[15] && voltHist2[15];
	assign marginsOk = (magnitude(next_voltFiltered) >= `CROSS_MARGIN) &&
		(magnitude(voltHist1) >= `CROSS_MARGIN);
	assign validCrossing = marginsOk && ((newPositive && histNegative) || (newNegative && histPositive));

	// watchdog and dc-removal period counting
	reg [5:0] periodCount;
	wire watchdogExpire;
	wire periodTick;
	wire dcAnyEnabled;
	wire [5:0] periodTarget;

	assign watchdogExpire = !validCrossing && (watchdogCount + 8'h01 == `WATCHDOG_LIMIT);
	assign periodTick = validCrossing || watchdogExpire;
	assign dcAnyEnabled = control[`CTL_VOLT_DC] || control[`CTL_CUR1_DC] || control[`CTL_CUR2_DC];
	assign periodTarget = (dcRemovalPeriodCount == 6'h00) ? 6'h01 : dcRemovalPeriodCount;

	always @(posedge ref_clk) begin
		if (rst) begin
			voltHist1 <= 16'h0000;
			voltHist2 <= 16'h0000;
			filteredVoltSample <= 16'h0000;
			filteredStrobe <= 1'b0;
			crossingPulse <= 1'b0;
			dcRemovalStep <= 1'b0;
			watchdogCount <= 8'h00;
			periodCount <= 6'h00;
		end else begin
			filteredStrobe <= sampleStrobe;
			crossingPulse <= sampleStrobe && validCrossing;
			dcRemovalStep <= 1'b0;
			if (sampleStrobe) begin
				voltHist1 <= next_voltFiltered;
				voltHist2 <= voltHist1;
				filteredVoltSample <= next_voltFiltered;
				if (periodTick)
					watchdogCount <= 8'h00;
				else
					watchdogCount <= watchdogCount + 8'h01;
				if (periodTick && dcAnyEnabled) begin
					if (periodCount + 6'h01 >= periodTarget) begin
						periodCount <= 6'h00;
						dcRemovalStep <= 1'b1;
					end else begin
						periodCount <= periodCount + 6'h01;
					end
				end else if (!dcAnyEnabled) begin
					periodCount <= 6'h00;
				end
			end
		end
	end

	// overpeak detection, one lane per channel
	wire [47:0] laneSamples;
	wire [44:0] laneThresholds;
	wire [2:0] laneExceed;
	wire [2:0] laneFlag;

	assign laneSamples = {curSample2, curSample1, voltSample};
	assign laneThresholds = {currentPeakThreshold, currentPeakThreshold, voltagePeakThreshold};

	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : lane
			reg [1:0] runCount;
			reg flag;
			assign laneExceed[g] = magnitude(laneSamples[g*16 +: 16]) > {2'b00, laneThresholds[g*15 +: 15]};
			assign laneFlag[g] = flag;
			always @(posedge ref_clk) begin
				if (rst) begin
					runCount <= 2'h0;
					flag <= 1'b0;
				end else if (sampleStrobe) begin
					if (!laneExceed[g]) begin
						runCount <= 2'h0;
						flag <= 1'b0;
					end else begin
						if (runCount != `EXCEED_RUN)
							runCount <= runCount + 2'h1;
						// run saturates at three, so the flag holds on longer runs
						flag <= (runCount >= `EXCEED_RUN - 2'h1);
					end
				end
			end
		end
	endgenerate

	always @(posedge ref_clk) begin
		if (rst) begin
			voltageOverpeakFlag <= 1'b0;
			firstChannelOvercurrentFlag <= 1'b0;
			secondChannelOvercurrentFlag <= 1'b0;
			voltOffset <= 16'h0000;
			curOffset1 <= 16'h0000;
			curOffset2 <= 16'h0000;
		end else begin
			voltageOverpeakFlag <= laneFlag[0];
			firstChannelOvercurrentFlag <= laneFlag[1];
			secondChannelOvercurrentFlag <= laneFlag[2];
			voltOffset <= control[`CTL_VOLT_DC] ? voltOffsetIn : 16'h0000;
			curOffset1 <= control[`CTL_CUR1_DC] ? curOffset1In : 16'h0000;
			curOffset2 <= control[`CTL_CUR2_DC] ? curOffset2In : 16'h0000;
		end
	end

	// common-mode compensation
	reg [31:0] heldBlock1;
	reg [31:0] heldBlock2;
	reg [31:0] heldReactive;
	reg [31:0] rmsSquare;
	reg [17:0] divisorHeld;
	reg divStart;
	reg compPending;
	wire divBusy;
	wire divDone;
	wire [31:0] divQuotient;
	wire [31:0] freshComp;
	wire [31:0] correctedBlock1;
	wire [31:0] squareActive;
	wire [31:0] squareReactive;

	assign freshComp = (divisorHeld == 18'h00000) ? 32'h00000000 : divQuotient;
	assign correctedBlock1 = heldBlock1 - freshComp;
	assign squareActive = correctedBlock1[31] ? (32'h00000000 - correctedBlock1) : correctedBlock1;
	assign squareReactive = heldReactive[31] ? (32'h00000000 - heldReactive) : heldReactive;

	comp_divider divider (
		.ref_clk(ref_clk),
		.rst(rst),
		.start(divStart),
		.dividend(rmsSquare),
		.divisor(divisorHeld),
		.busy(divBusy),
		.done(divDone),
		.quotient(divQuotient)
	);

	always @(posedge ref_clk) begin
		if (rst) begin
			heldBlock1 <= 32'h00000000;
			heldBlock2 <= 32'h00000000;
			heldReactive <= 32'h00000000;
			rmsSquare <= 32'h00000000;
			divisorHeld <= 18'h00000;
			divStart <= 1'b0;
			compPending <= 1'b0;
			commonModeCompensationValue <= 32'h00000000;
			prevCompensation <= 32'h00000000;
			blockValid <= 1'b0;
			firstBlockActiveEnergy <= 32'h00000000;
			secondBlockActiveEnergy <= 32'h00000000;
			blockReactiveEnergy <= 32'h00000000;
			blockApparentSquare <= 64'h0000000000000000;
			periodValid <= 1'b0;
			firstPeriodActiveEnergy <= 32'h00000000;
			secondPeriodActiveEnergy <= 32'h00000000;
			levelValid <= 1'b0;
			levelActiveEnergy <= 32'h00000000;
		end else begin
			divStart <= 1'b0;
			blockValid <= 1'b0;
			if (blockDone && !compPending) begin
				heldBlock1 <= firstBlockActiveEnergyIn;
				heldBlock2 <= secondBlockActiveEnergyIn;
				heldReactive <= blockReactiveEnergyIn;
				rmsSquare <= voltageRmsResult * voltageRmsResult;
				divisorHeld <= {commonModeParameter, 2'b00};
				divStart <= 1'b1;
				compPending <= 1'b1;
			end else if (compPending && divDone && !divBusy) begin
				compPending <= 1'b0;
				commonModeCompensationValue <= freshComp;
				prevCompensation <= freshComp;
				blockValid <= 1'b1;
				firstBlockActiveEnergy <= correctedBlock1;
				secondBlockActiveEnergy <= heldBlock2 - freshComp;
				blockReactiveEnergy <= heldReactive;
				blockApparentSquare <= squareActive * squareActive + squareReactive * squareReactive;
			end
			periodValid <= periodDone;
			if (periodDone) begin
				firstPeriodActiveEnergy <= firstPeriodActiveEnergyIn - prevCompensation;
				secondPeriodActiveEnergy <= secondPeriodActiveEnergyIn - prevCompensation;
			end
			levelValid <= levelUpdate;
			if (levelUpdate) begin
				if (control[`CTL_LEVEL_MODE])
					levelActiveEnergy <= levelActiveEnergyIn;
				else
					levelActiveEnergy <= levelActiveEnergyIn - prevCompensation;
			end
		end
	end

endmodule // metering_sample_monitor

// file: test/sample_monitor_props.sv
// port-level assertions for the sample monitor
// bound to every metering_sample_monitor instance; one clock domain
`timescale 1ns/1ps

module sample_monitor_props (
	// clock and reset
	input wire ref_clk,
	input wire rst,
	// bus
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_ack_o,
	// samples
	input wire sampleStrobe,
	input wire [15:0] filteredVoltSample,
	input wire filteredStrobe,
	input wire voltageOverpeakFlag,
	input wire firstChannelOvercurrentFlag,
	input wire crossingPulse,
	input wire dcRemovalStep,
	// energies
	input wire blockDone,
	input wire [31:0] blockReactiveEnergyIn,
	input wire blockValid,
	input wire [31:0] blockReactiveEnergy,
	input wire periodDone,
	input wire periodValid,
	input wire levelUpdate,
	input wire levelValid
);
	logic [31:0] heldReactive;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	always @(posedge ref_clk) begin
		if (blockDone)
			heldReactive <= blockReactiveEnergyIn;
	end

	ack_next_cycle_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered in one cycle");
	ack_single_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus ack longer than one cycle");
	filtered_strobe_a: assert property (1'b1 |=> filteredStrobe == $past(sampleStrobe))
		else $error("filtered strobe not one cycle after sample strobe");
	volt_flag_run_a: assert property ($rose(voltageOverpeakFlag) |-> $past(sampleStrobe, 2))
		else $error("voltage flag rose without a sample");
	cur_flag_run_a: assert property ($rose(firstChannelOvercurrentFlag) |-> $past(sampleStrobe, 2))
		else $error("current flag rose without a sample");
	crossing_margin_a: assert property (crossingPulse |-> filteredStrobe &&
		($signed(filteredVoltSample) >= 16'sh01f6 || $signed(filteredVoltSample) <= -16'sh01f6))
		else $error("crossing accepted inside the noise margin");
	step_after_strobe_a: assert property (dcRemovalStep |-> $past(sampleStrobe))
		else $error("removal step without a sample");
	block_latency_a: assert property (blockDone |-> ##35 blockValid)
		else $error("block result late or missing");
	reactive_passthru_a: assert property (blockValid |-> blockReactiveEnergy == heldReactive)
		else $error("reactive energy altered");
	period_answer_a: assert property (periodDone |=> periodValid)
		else $error("period result missing");
	level_answer_a: assert property (levelUpdate |=> levelValid)
		else $error("level result missing");
endmodule // sample_monitor_props

bind metering_sample_monitor sample_monitor_props props (.ref_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
	.sampleStrobe, .filteredVoltSample, .filteredStrobe, .voltageOverpeakFlag, .firstChannelOvercurrentFlag,
	.crossingPulse, .dcRemovalStep, .blockDone, .blockReactiveEnergyIn, .blockValid, .blockReactiveEnergy,
	.periodDone, .periodValid, .levelUpdate, .levelValid);

// file: test/afe_source.sv
// sample and energy feed standing in for the front end and accumulator
// tasks are called just after a rising edge; released lines show inverted data
`timescale 1ns/1ps

module afe_source (
	// clock
	input wire ref_clk,
	// sample stream
	output logic sampleStrobe = 1'b0,
	output logic [15:0] voltSample = 16'h0,
	output logic [15:0] curSample1 = 16'h0,
	output logic [15:0] curSample2 = 16'h0,
	// energy results
	output logic [15:0] voltageRmsResult = 16'h0,
	output logic blockDone = 1'b0,
	output logic periodDone = 1'b0,
	output logic levelUpdate = 1'b0,
	output logic [31:0] firstEnergy = 32'h0,
	output logic [31:0] secondEnergy = 32'h0,
	output logic [31:0] reactiveEnergy = 32'h0
);
	// one sample, returning once flags have settled
	task automatic sample(input logic [15:0] v, input logic [15:0] c1, input logic [15:0] c2);
		voltSample <= v;
		curSample1 <= c1;
		curSample2 <= c2;
		sampleStrobe <= 1'b1;
		@(posedge ref_clk);
		sampleStrobe <= 1'b0;
		voltSample <= ~v;
		curSample1 <= ~c1;
		curSample2 <= ~c2;
		repeat (3) @(posedge ref_clk);
	endtask

	// kind 0 block, 1 period, 2 level; spaced wider than a block computation
	task automatic energy(input int kind, input logic [15:0] rms, input logic [31:0] act, input logic [31:0] re);
		voltageRmsResult <= rms;
		firstEnergy <= act;
		secondEnergy <= act + 32'h1;
		reactiveEnergy <= re;
		blockDone <= (kind == 0);
		periodDone <= (kind == 1);
		levelUpdate <= (kind == 2);
		@(posedge ref_clk);
		{blockDone, periodDone, levelUpdate} <= 3'h0;
		firstEnergy <= ~act;
		secondEnergy <= ~(act + 32'h1);
		reactiveEnergy <= ~re;
		voltageRmsResult <= ~rms;
		repeat (39) @(posedge ref_clk);
	endtask
endmodule // afe_source

// file: test/metering_sample_monitor_test.sv
// self-checking bench: registers, flags, filter, crossings, watchdog, offsets, energies
// assumes afe_source as feed and the props checker bound to the design
`timescale 1ns/1ps
`include "sample_monitor_defines.vh"

module metering_sample_monitor_test;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h0;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [15:0] voltOffsetIn = 16'h1234, curOffset1In = 16'h2345, curOffset2In = 16'h3456;
	wire [31:0] wb_dat_o, firstEnergy, secondEnergy, reactiveEnergy;
	wire [31:0] firstBlockActiveEnergy, secondBlockActiveEnergy, blockReactiveEnergy;
	wire [31:0] firstPeriodActiveEnergy, secondPeriodActiveEnergy, levelActiveEnergy;
	wire [63:0] blockApparentSquare;
	wire [15:0] voltSample, curSample1, curSample2, voltageRmsResult, filteredVoltSample;
	wire [15:0] voltOffset, curOffset1, curOffset2;
	wire wb_ack_o, sampleStrobe, blockDone, periodDone, levelUpdate, filteredStrobe, crossingPulse, dcRemovalStep;
	wire voltageOverpeakFlag, firstChannelOvercurrentFlag, secondChannelOvercurrentFlag;
	wire blockValid, periodValid, levelValid;
	int nFail = 0, samplesChecked = 0, cycles = 0, nCross = 0, nStep = 0, n0;
	logic [63:0] app;

	afe_source src (.ref_clk, .sampleStrobe, .voltSample, .curSample1, .curSample2, .voltageRmsResult,
		.blockDone, .periodDone, .levelUpdate, .firstEnergy, .secondEnergy, .reactiveEnergy);

	metering_sample_monitor dut (.ref_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .sampleStrobe, .voltSample, .curSample1, .curSample2, .voltOffsetIn,
		.curOffset1In, .curOffset2In, .voltageRmsResult, .blockDone, .firstBlockActiveEnergyIn(firstEnergy),
		.secondBlockActiveEnergyIn(secondEnergy), .blockReactiveEnergyIn(reactiveEnergy), .periodDone,
		.firstPeriodActiveEnergyIn(firstEnergy), .secondPeriodActiveEnergyIn(secondEnergy), .levelUpdate,
		.levelActiveEnergyIn(firstEnergy), .filteredVoltSample, .filteredStrobe, .voltageOverpeakFlag,
		.firstChannelOvercurrentFlag, .secondChannelOvercurrentFlag, .crossingPulse, .dcRemovalStep,
		.voltOffset, .curOffset1, .curOffset2, .blockValid, .firstBlockActiveEnergy, .secondBlockActiveEnergy,
		.blockReactiveEnergy, .blockApparentSquare, .periodValid, .firstPeriodActiveEnergy,
		.secondPeriodActiveEnergy, .levelValid, .levelActiveEnergy);

	always #2 ref_clk = ~ref_clk;

	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (crossingPulse === 1'b1)
			nCross <= nCross + 1;
		if (dcRemovalStep === 1'b1)
			nStep <= nStep + 1;
		if (cycles == 20000) begin
			nFail++;
			summarize();
		end
	end

	task automatic summarize;
		$display("comparisons %0d, mismatches %0d", samplesChecked, nFail);
		if (nFail == 0 && samplesChecked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			nFail++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// classic single cycle, held until ack, then one idle cycle
	task automatic access(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] q);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'hf;
		wb_dat_i <= dat;
		@(posedge ref_clk);
		while (wb_ack_o !== 1'b1)
			@(posedge ref_clk);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
		logic [31:0] q;
		access(1'b1, adr, dat, q);
	endtask

	task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
		logic [31:0] q;
		access(1'b0, adr, 32'h0, q);
		check(q, exp);
	endtask

	task automatic flags(input logic [2:0] exp);
		check({29'h0, voltageOverpeakFlag, firstChannelOvercurrentFlag, secondChannelOvercurrentFlag}, {29'h0, exp});
	endtask

	initial begin
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		rdchk(`ADR_VOLT_PEAK, 32'h7fff);
		rdchk(`ADR_CUR_PEAK, 32'h7fff);
		rdchk(`ADR_DC_PERIOD, 32'h5);
		rdchk(`ADR_COMMON_MODE, 32'h0);
		wr(`ADR_DC_PERIOD, 32'h3f);
		rdchk(`ADR_DC_PERIOD, 32'h32);
		wr(8'h40, 32'hffff);
		rdchk(8'h40, 32'h0);
		for (int m = 0; m < 8; m++) begin
			wr(`ADR_CONTROL, m);
			@(posedge ref_clk);
			check({voltOffset, curOffset1}, {m[0] ? 16'h1234 : 16'h0, m[1] ? 16'h2345 : 16'h0});
			check({16'h0, curOffset2}, {16'h0, m[2] ? 16'h3456 : 16'h0});
		end
		wr(`ADR_CONTROL, 32'h0);
		// three-sample runs; channel two is broken by a sample equal to the threshold
		wr(`ADR_VOLT_PEAK, 32'h64);
		wr(`ADR_CUR_PEAK, 32'h32);
		src.sample(16'h65, 16'h33, 16'h33);
		src.sample(16'hff9b, 16'hffcd, 16'h32);
		flags(3'h0);
		src.sample(16'h65, 16'h33, 16'h33);
		flags(3'h6);
		// a fourth exceeding sample keeps the flags up
		src.sample(16'h65, 16'h33, 16'h32);
		flags(3'h6);
		src.sample(16'h64, 16'h32, 16'h33);
		flags(3'h0);
		wr(`ADR_VOLT_PEAK, 32'h7fff);
		// spike filter off, then on
		src.sample(16'h4e20, 16'h0, 16'h0);
		check({16'h0, filteredVoltSample}, 32'h4e20);
		wr(`ADR_MAX_DELTA, 32'h3e8);
		wr(`ADR_CONTROL, 32'h8);
		src.sample(16'h4e84, 16'h0, 16'h0);
		src.sample(16'h4ee8, 16'h0, 16'h0);
		check({16'h0, filteredVoltSample}, 32'h4ee8);
		src.sample(16'h52d0, 16'h0, 16'h0);
		check({16'h0, filteredVoltSample}, 32'h4f4c);
		wr(`ADR_CONTROL, 32'h0);
		// falling, rising, then a crossing inside the margin
		n0 = nCross;
		src.sample(16'hfda8, 16'h0, 16'h0);
		src.sample(16'hfda8, 16'h0, 16'h0);
		src.sample(16'h0258, 16'h0, 16'h0);
		check(nCross - n0, 32'h2);
		src.sample(16'h0258, 16'h0, 16'h0);
		src.sample(16'hfe0b, 16'h0, 16'h0);
		check(nCross - n0, 32'h2);
		// watchdog with one period per step
		wr(`ADR_CONTROL, 32'h1);
		wr(`ADR_DC_PERIOD, 32'h1);
		src.sample(16'hfda8, 16'h0, 16'h0);
		src.sample(16'hfda8, 16'h0, 16'h0);
		n0 = nStep;
		src.sample(16'h0258, 16'h0, 16'h0);
		check(nStep - n0, 32'h1);
		repeat (141) src.sample(16'h0258, 16'h0, 16'h0);
		check(nStep - n0, 32'h1);
		src.sample(16'h0258, 16'h0, 16'h0);
		check(nStep - n0, 32'h2);
		rdchk(`ADR_STATUS, 32'h0);
		// common-mode compensation
		wr(`ADR_CONTROL, 32'h0);
		src.energy(0, 16'h100, 32'h2710, 32'h12c);
		check(firstBlockActiveEnergy, 32'h2710);
		wr(`ADR_COMMON_MODE, 32'h4);
		src.energy(1, 16'h100, 32'h1388, 32'h0);
		check(firstPeriodActiveEnergy, 32'h1388);
		src.energy(0, 16'h100, 32'h2710, 32'h12c);
		rdchk(`ADR_COMP_VALUE, 32'h10000 / 32'h10);
		check(firstBlockActiveEnergy, 32'h2710 - 32'h1000);
		check(secondBlockActiveEnergy, 32'h2711 - 32'h1000);
		check(blockReactiveEnergy, 32'h12c);
		app = 64'h1710 * 64'h1710 + 64'h12c * 64'h12c;
		check(blockApparentSquare[63:32], app[63:32]);
		check(blockApparentSquare[31:0], app[31:0]);
		src.energy(1, 16'h0, 32'h1388, 32'h0);
		check(secondPeriodActiveEnergy, 32'h1389 - 32'h1000);
		src.energy(2, 16'h0, 32'h1388, 32'h0);
		check(levelActiveEnergy, 32'h1388 - 32'h1000);
		wr(`ADR_CONTROL, 32'h10);
		src.energy(2, 16'h0, 32'h1388, 32'h0);
		check(levelActiveEnergy, 32'h1388);
		summarize();
	end
endmodule // metering_sample_monitor_test
